// ---- include/alarm_led_pkg.sv ----
// constants for the rectifier status and alarm encoder
// assumes a 125 MHz clock and an axi4-lite register port
package alarm_led_pkg;
  localparam int CLK_MHZ = 125;
  localparam int BLINK_MS_HALF = 250;
  localparam int BLINK_CYCLES = BLINK_MS_HALF * 1000 * CLK_MHZ;
  localparam int POWER_FAIL_LEAD_MS = 5;
  localparam int POWER_FAIL_LEAD_CYCLES = POWER_FAIL_LEAD_MS * 1000 * CLK_MHZ;
  localparam int WARN_MARGIN_C = 5;
  localparam logic [7:0] WARN_MARGIN = 8'h05;
  localparam logic [7:0] ADDR_COND = 8'h00;
  localparam logic [7:0] ADDR_TEMP = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ALERT = 8'h0C;
  localparam int COND_THERM_SD = 0;
  localparam int COND_FAN = 1;
  localparam int COND_FUSE = 2;
  localparam int COND_BOOST_FAIL = 3;
  localparam int COND_OV_LATCH = 4;
  localparam int COND_INPUT_BAD = 5;
  localparam int COND_OVERCURRENT = 6;
  localparam int COND_SOFT_FAIL = 7;
  localparam int COND_STANDBY = 8;
  localparam int COND_SERVICE = 9;
  localparam int COND_COMM = 10;
  localparam int COND_HIGH_LINE = 11;
  localparam int COND_WIDTH = 12;
  localparam logic [31:0] COND_RESET = 32'h0000_0800;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {MODE_BUS, MODE_MULTIDROP} proto_mode_t;
endpackage

// ---- logic/alarm_led_encoder.sv ----
// status and alarm encoder: front-panel indicators, alarm outputs and control gating
// assumes condition bits and temperatures come from firmware over axi4-lite
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module alarm_led_encoder
  import alarm_led_pkg::*;
(
  input wire logic clk, // 125 MHz
  input wire logic rst_b, // async, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic enable_n_pin, // output enable in bus mode, low = on; ignored in multidrop
  input wire logic hotplug_on_pin, // short hot-plug contact made
  input wire logic protocol_open_pin, // high when select pin open
  input wire logic margin_pin, // margin request
  input wire logic mux_reset_pin, // bus mux reset request
  input wire logic input_present_pin, // input power present
  input wire logic back_bias_rail, // held up by shelf neighbours
  input wire logic boost_low_pin, // boost voltage decaying
  output logic led_input_ok, // green input ok
  output logic led_output_ok, // green output ok
  output logic led_service, // amber service
  output logic led_fault, // red fault
  output logic fault_n, // fault alarm, low active
  output logic power_fail_warning_n, // low before output drop
  output logic overtemp_warning_n, // low near shutdown
  output logic capacity_indicator, // high at full capacity
  output logic module_seated_n, // low while seated
  output logic [1:0] alert_n, // per-bus alert, low active
  output logic main_output_on, // main converter run
  output logic margin_active, // shift set point
  output logic mux_reset, // resets bus mux
  output logic protocol_multidrop // multidrop mode selected
);
  logic [10:0] pin_s1, pin_s2;
  logic [COND_WIDTH-1:0] cond;
  logic [7:0] temp_now, temp_shutdown;
  logic [1:0] alert_req;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] blink_cnt;
  logic blink;
  logic [31:0] lead_cnt;
  logic warn_early;
  logic sync_en_n, sync_hot, sync_proto, sync_margin, sync_mux, sync_inp, sync_bias, sync_boost;
  logic next_in, next_out, next_srv, next_flt, next_fault_n, next_pf_n, next_ot_n;
  proto_mode_t mode;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // two-flop synchronisers for every pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= 11'h001;
      pin_s2 <= 11'h001;
    end else begin
      pin_s1 <= {3'h0, boost_low_pin, back_bias_rail, input_present_pin, mux_reset_pin, margin_pin,
                 protocol_open_pin, hotplug_on_pin, enable_n_pin};
      pin_s2 <= pin_s1;
    end
  end
  assign {sync_boost, sync_bias, sync_inp, sync_mux, sync_margin, sync_proto, sync_hot, sync_en_n} = pin_s2[7:0];
  // open select pin means bus mode
  assign mode = sync_proto ? MODE_BUS : MODE_MULTIDROP;

  // axi4-lite write: address and data taken independently, response after both
  logic do_write;
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == ADDR_COND || aw_addr == ADDR_TEMP || aw_addr == ADDR_ALERT) ? RESP_OKAY
                                                                                              : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
    end
  end

  // software-written state; a write of zero must clear, so the merged word is taken whole
  logic [31:0] cond_merged, temp_merged, alert_merged;
  assign cond_merged = merge({20'h0, cond}, w_data, w_strb);
  assign temp_merged = merge({16'h0, temp_shutdown, temp_now}, w_data, w_strb);
  assign alert_merged = merge({30'h0, alert_req}, w_data, w_strb);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cond <= COND_RESET[COND_WIDTH-1:0];
      temp_now <= 8'h00;
      temp_shutdown <= 8'hFF;
      alert_req <= 2'h0;
    end else if (do_write) begin
      case (aw_addr)
        ADDR_COND: cond <= cond_merged[COND_WIDTH-1:0];
        ADDR_TEMP: {temp_shutdown, temp_now} <= temp_merged[15:0];
        ADDR_ALERT: alert_req <= alert_merged[1:0];
        default: ;
      endcase
    end
  end

  // axi4-lite read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_COND: s_axi_rdata <= {20'h0, cond};
          ADDR_TEMP: s_axi_rdata <= {16'h0, temp_shutdown, temp_now};
          ADDR_STATUS: s_axi_rdata <= {19'h0, protocol_multidrop, main_output_on, module_seated_n,
                                       capacity_indicator, overtemp_warning_n, power_fail_warning_n,
                                       fault_n, led_fault, led_service, led_output_ok, led_input_ok,
                                       1'b0, 1'b0};
          ADDR_ALERT: s_axi_rdata <= {30'h0, alert_req};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // blink timebase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b0;
    end else if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      blink_cnt <= 32'h0000_0000;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  // boost decay warns ahead of output collapse; converter holds off the drop for this long
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lead_cnt <= 32'h0000_0000;
      warn_early <= 1'b0;
    end else if (sync_boost) begin
      warn_early <= 1'b1;
      if (lead_cnt < 32'(POWER_FAIL_LEAD_CYCLES)) begin
        lead_cnt <= lead_cnt + 32'h0000_0001;
      end
    end else begin
      lead_cnt <= 32'h0000_0000;
      warn_early <= 1'b0;
    end
  end

  // priority encoding of the status table
  logic hard_fault, near_hot;
  assign hard_fault = cond[COND_FAN] | cond[COND_FUSE] | cond[COND_BOOST_FAIL] | cond[COND_OV_LATCH];
  assign near_hot = (temp_now >= temp_shutdown - WARN_MARGIN) || (temp_shutdown < WARN_MARGIN);
  always_comb begin
    next_in = 1'b1;
    next_out = 1'b1;
    next_srv = 1'b0;
    next_flt = 1'b0;
    next_fault_n = 1'b1;
    next_pf_n = !warn_early;
    next_ot_n = !near_hot;
    if (!sync_inp) begin
      next_in = 1'b0;
      next_out = 1'b0;
      next_pf_n = !sync_bias ? 1'b0 : 1'b0;
      next_ot_n = 1'b1;
    end else if (cond[COND_THERM_SD]) begin
      next_out = 1'b0;
      next_srv = 1'b1;
      next_flt = 1'b1;
      next_fault_n = 1'b0;
      next_pf_n = 1'b0;
      next_ot_n = 1'b0;
    end else if (hard_fault) begin
      next_out = 1'b0;
      next_flt = 1'b1;
      next_fault_n = 1'b0;
      next_pf_n = 1'b0;
      next_ot_n = 1'b1;
    end else if (cond[COND_INPUT_BAD]) begin
      next_in = blink;
      next_out = 1'b0;
      next_ot_n = 1'b1;
    end else if (cond[COND_STANDBY] || !main_output_on) begin
      next_out = 1'b0;
      next_pf_n = 1'b0;
    end else if (cond[COND_OVERCURRENT]) begin
      next_out = blink;
      next_pf_n = 1'b0;
    end else begin
      if (near_hot) begin
        next_srv = 1'b1;
      end
      if (cond[COND_SOFT_FAIL]) begin
        next_flt = 1'b1;
        next_fault_n = 1'b0;
      end else if (mode == MODE_MULTIDROP && cond[COND_COMM]) begin
        next_flt = blink;
      end
      if (mode == MODE_BUS && cond[COND_SERVICE] && !near_hot) begin
        next_srv = blink;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_input_ok <= 1'b0;
      led_output_ok <= 1'b0;
      led_service <= 1'b0;
      led_fault <= 1'b0;
      fault_n <= 1'b1;
      power_fail_warning_n <= 1'b0;
      overtemp_warning_n <= 1'b1;
      capacity_indicator <= 1'b1;
      module_seated_n <= 1'b0;
      alert_n <= 2'h3;
      main_output_on <= 1'b0;
      margin_active <= 1'b0;
      mux_reset <= 1'b0;
      protocol_multidrop <= 1'b0;
    end else begin
      led_input_ok <= next_in;
      led_output_ok <= next_out;
      led_service <= next_srv;
      led_fault <= next_flt;
      fault_n <= next_fault_n;
      power_fail_warning_n <= next_pf_n;
      overtemp_warning_n <= next_ot_n;
      capacity_indicator <= cond[COND_HIGH_LINE];
      module_seated_n <= 1'b0;
      alert_n <= ~alert_req;
      main_output_on <= sync_hot && (mode == MODE_MULTIDROP || !sync_en_n);
      margin_active <= sync_margin;
      mux_reset <= sync_mux;
      protocol_multidrop <= (mode == MODE_MULTIDROP);
    end
  end

  fault_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sync_inp && hard_fault && !cond[COND_THERM_SD]) |=> (!fault_n && led_fault && !led_output_ok))
    else $error("hard fault not indicated");
  output_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    !sync_hot |=> !main_output_on) else $error("output on without contact");
  alert_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> alert_n == ~$past(alert_req)) else $error("alert mismatch");
  temp_warn_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sync_inp && near_hot && !hard_fault && !cond[COND_INPUT_BAD]) |=> !overtemp_warning_n)
    else $error("overtemp warning not low");
  capacity_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> capacity_indicator == $past(cond[COND_HIGH_LINE])) else $error("capacity mismatch");
  fail_lead_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lead_cnt != 32'h0000_0000) |=> !power_fail_warning_n) else $error("power fail warning not low");
endmodule

// ---- dv/shelf_host.sv ----
// host model: shelf controller that owns the register bus and the strap pins
// assumes the encoder's axi4-lite slave and one free-running clk
`timescale 1ns/10ps
module shelf_host (
  input wire logic clk, // bus clock
  output logic [7:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte enables
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  output logic s_axi_bready, // write response ready
  output logic [7:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready, // read data ready
  output logic enable_n_pin, // strap to signal_ground turns output on
  output logic protocol_open_pin // open strap selects bus mode
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    enable_n_pin = 1'b0;
    protocol_open_pin = 1'b1;
  end
  task automatic set_straps(input logic en_n, input logic open);
    enable_n_pin <= en_n;
    protocol_open_pin <= open;
  endtask
  // ready is registered, so its value at the falling edge is what the next rising edge takes
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp, output bit to);
    bit aw_t, w_t, b_t, aw_d, w_d;
    to = 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (int n = 0; n < 100 && to; n++) begin
      @(negedge clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = aw_d && w_d && s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      // released payload is scrambled so nothing can lean on a stale value
      if (aw_t) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (w_t) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (b_t) s_axi_bready <= 1'b0;
      aw_d |= aw_t;
      w_d |= w_t;
      to = !b_t;
    end
    @(posedge clk);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [33:0] rsp, output bit to);
    bit ar_t, r_t, ar_d;
    to = 1'b1;
    ar_d = 1'b0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (int n = 0; n < 100 && to; n++) begin
      @(negedge clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = ar_d && s_axi_rvalid;
      rsp = {s_axi_rresp, s_axi_rdata};
      @(posedge clk);
      if (ar_t) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (r_t) s_axi_rready <= 1'b0;
      ar_d |= ar_t;
      to = !r_t;
    end
    @(posedge clk);
  endtask
endmodule

// ---- dv/tb.sv ----
// bench: drives the encoder's pins and registers, compares against an integer model
// assumes shelf_host as bus master; blinking indications are masked (half period too long)
`timescale 1ns/10ps
module tb;
  import alarm_led_pkg::*;
  logic clk, rst_b, hotplug_on_pin, margin_pin, mux_reset_pin, input_present_pin, back_bias_rail, boost_low_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, alert_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, enable_n_pin, protocol_open_pin;
  logic led_input_ok, led_output_ok, led_service, led_fault, fault_n, power_fail_warning_n, overtemp_warning_n;
  logic capacity_indicator, module_seated_n, main_output_on, margin_active, mux_reset, protocol_multidrop;
  wire logic [15:0] state = {1'b0, led_input_ok, led_output_ok, led_service, led_fault, fault_n,
    power_fail_warning_n, overtemp_warning_n, capacity_indicator, module_seated_n, main_output_on,
    margin_active, mux_reset, protocol_multidrop, alert_n};
  int mismatches, compares, seed, v;
  int conds[$] = '{'h800, 'h801, 'h802, 'h804, 'h808, 'h810, 'h820, 'h840, 'h880, 'h900, 'hA00};
  alarm_led_encoder i_dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .enable_n_pin(enable_n_pin), .hotplug_on_pin(hotplug_on_pin), .protocol_open_pin(protocol_open_pin),
    .margin_pin(margin_pin), .mux_reset_pin(mux_reset_pin), .input_present_pin(input_present_pin),
    .back_bias_rail(back_bias_rail), .boost_low_pin(boost_low_pin), .led_input_ok(led_input_ok),
    .led_output_ok(led_output_ok), .led_service(led_service), .led_fault(led_fault), .fault_n(fault_n),
    .power_fail_warning_n(power_fail_warning_n), .overtemp_warning_n(overtemp_warning_n),
    .capacity_indicator(capacity_indicator), .module_seated_n(module_seated_n), .alert_n(alert_n),
    .main_output_on(main_output_on), .margin_active(margin_active), .mux_reset(mux_reset),
    .protocol_multidrop(protocol_multidrop));
  shelf_host i_host (.clk(clk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .enable_n_pin(enable_n_pin), .protocol_open_pin(protocol_open_pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // {mask, expected} for in_ok,out_ok,srv,flt,fault_n,pfail_n,otemp_n; a zero mask bit hides a blinking indicator, or pfail_n under input bad
  function automatic logic [13:0] model(int c, int t, bit ac, bit md);
    bit hot;
    hot = (t & 'hFF) + WARN_MARGIN_C >= ((t >> 8) & 'hFF);
    if (!ac) return {7'h7F, 7'b0000101};
    if (c[0]) return {7'h7F, 7'b1011000};
    if ((c & 'h1E) != 0) return {7'h7F, 7'b1001001};
    if (c[5]) return {7'h3D, 7'b0000101};
    if (c[8]) return {7'h7F, 7'b1000101};
    if (c[6]) return {7'h5F, 7'b1000101};
    if (c[7]) return {7'h7F, 7'b1101011};
    if (hot) return {7'h7F, 7'b1110110};
    if (c[9] && !md) return {7'h6F, 7'b1100111};
    if (c[10] && md) return {7'h77, 7'b1100111};
    return {7'h7F, 7'b1100111};
  endfunction
  task automatic stop_test;
    $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check_pins(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
    compares++;
    if ((got & mask) !== (exp & mask)) begin
      mismatches++;
      $display("[FAIL] t=%0t pins got=%h exp=%h", $time, got & mask, exp & mask);
    end
  endtask
  task automatic check_bus(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t bus got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang;
    mismatches++;
    stop_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit to;
    @(posedge clk);
    i_host.write_reg(a, d, r, to);
    if (to) hang();
    check_bus({r, 32'h0}, {er, 32'h0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    logic [33:0] r;
    bit to;
    @(posedge clk);
    i_host.read_reg(a, r, to);
    if (to) hang();
    check_bus(r, exp);
  endtask
  // pins pass two sync flops and one output flop; six edges leaves margin off the sampling edge
  task automatic settle;
    repeat (6) @(posedge clk);
    #2;
  endtask
  task automatic run_case(input int c, input int t);
    logic [13:0] m;
    wr(ADDR_COND, c, RESP_OKAY);
    wr(ADDR_TEMP, t, RESP_OKAY);
    settle();
    m = model(c, t, input_present_pin, !protocol_open_pin);
    check_pins(state, {1'b0, m[6:0], 8'h00}, {1'b0, m[13:7], 8'h00});
  endtask
  initial begin
    {rst_b, margin_pin, mux_reset_pin, boost_low_pin} = 4'b0000;
    {hotplug_on_pin, input_present_pin, back_bias_rail} = 3'b111;
    {mismatches, compares, seed} = {32'd0, 32'd0, 32'd74553};
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_COND, {RESP_OKAY, COND_RESET});
    rd(8'h10, {RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h1, RESP_SLVERR);
    $display("test registers done");
    foreach (conds[i]) run_case(conds[i], 'hFF00);
    run_case('h800, 'h645F);
    run_case('h800, 'h645E);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_0BCC});
    @(posedge clk);
    i_host.set_straps(1'b0, 1'b0);
    run_case('hC00, 'hFF00);
    check_pins(state, 16'h0004, 16'h0004);
    run_case('h800, 'hFF00);
    @(posedge clk);
    i_host.set_straps(1'b0, 1'b1);
    $display("test conditions done");
    @(posedge clk);
    input_present_pin <= 1'b0;
    run_case('h800, 'hFF00);
    @(posedge clk);
    {input_present_pin, boost_low_pin} <= 2'b11;
    settle();
    check_pins(state, 16'h0000, 16'h0200);
    @(posedge clk);
    boost_low_pin <= 1'b0;
    settle();
    check_pins(state, 16'h0200, 16'h0200);
    $display("test power fail done");
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      @(posedge clk);
      {mux_reset_pin, margin_pin, hotplug_on_pin} <= v[6:4];
      i_host.set_straps(v[7], 1'b1);
      wr(ADDR_ALERT, v, RESP_OKAY);
      wr(ADDR_COND, {20'h0, v[8], 11'h000}, RESP_OKAY);
      settle();
      check_pins(state, {8'h00, v[8], 1'b0, !v[7] && v[4], v[5], v[6], 1'b0, ~v[1:0]}, 16'h00FF);
    end
    $display("test controls done");
    stop_test();
  end
endmodule
